// ---- design/fht_pkg.sv ----
// Constants and types for the USB host frame timer.
// How it works
// - Copy interval toggle into remaining toggle at zero.
// - Remaining counter decrements each bit time running.
// - At zero, reload period on next bit time.
// - Entering running reloads counter; new period next frame.
// - Frame number increments on every counter reload.
// - Frame number wraps from all ones to zero.
// - Frame number is 16 bits, upper half reserved.
// - Entering running advances frame number once.
// - Every frame number advance raises start-of-frame flag.
// - Low-speed start only when remaining >= cutoff.
// - Low-speed cutoff is an 11-bit field.
// - Low-speed cutoff resets to 1576.
// - Only the cutoff write command alters the cutoff after reset.
// - Frame period defaults to 11999 bit times.
`default_nettype none

package fht_pkg;

  // ==========================================================================
  // Widths
  localparam int FR_W = 14;
  localparam int FN_W = 16;
  localparam int LST_W = 11;
  localparam int ACC_W = 8;

  // ==========================================================================
  // Command codes on the microprocessor port
  localparam logic [7:0] CMD_RD_REMAIN = 8'h0E;
  localparam logic [7:0] CMD_RD_FRNUM = 8'h0F;
  localparam logic [7:0] CMD_RD_CUTOFF = 8'h11;
  localparam logic [7:0] CMD_WR_CUTOFF = 8'h91;

  // ==========================================================================
  // Field positions and reset values
  localparam int FRT_POS = 31;
  localparam logic [LST_W-1:0] LST_RESET = 11'h628;
  localparam logic [FR_W-1:0] FI_RESET = 14'h2_EDF;
  localparam logic [FR_W-1:0] FR_RESET = 14'h0_000;
  localparam logic [FN_W-1:0] FN_RESET = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ==========================================================================
  // Bit-time tick: a fractional accumulator adds the bit rate each system
  // clock and wraps at the system rate, so ticks average exactly 12 MHz.
  localparam int SYS_CLK_MHZ = 200;
  localparam int BIT_RATE_MHZ = 12;
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BIT_RATE_MHZ);
  localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(SYS_CLK_MHZ);
  localparam logic [ACC_W-1:0] ACC_RESET = 8'h00;

  // ==========================================================================
  // Frame generation state, Gray coded along idle, start, run.
  typedef enum logic [1:0] {
    FHT_IDLE = 2'b00,
    FHT_START = 2'b01,
    FHT_RUN = 2'b11
  } fht_state_type;

endpackage

`default_nettype wire

// ---- design/fht_tick_if.sv ----
// Bit-time tick carrier between the tick generator and the frame timer.
`timescale 1ns/1ps
`default_nettype none

interface fht_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

`default_nettype wire

// ---- design/fht_bit_tick.sv ----
// Full-speed bit-time tick generator from the 200 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

module fht_bit_tick (
  input wire logic sys_clk,
  input wire logic rst,
  fht_tick_if.src tk
);
  import fht_pkg::*;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic tick_q;
  logic [ACC_W-1:0] acc_sum;
  logic acc_over;

  // ==========================================================================
  // Accumulator
  // Tick spacing jitters by one clock; the long-term rate is exact.
  assign acc_sum = acc_q + ACC_STEP;
  assign acc_over = acc_sum >= ACC_WRAP;
  assign acc_d = acc_over ? ACC_W'(acc_sum - ACC_WRAP) : acc_sum;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= ACC_RESET;
      tick_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick_q <= acc_over;
    end
  end

  assign tk.tick = tick_q;

  // ==========================================================================
  // Checks
  a_tick_isolated: assert property (@(posedge sys_clk) disable iff (rst)
    tick_q |=> !tick_q)
    else $error("Bit tick lasted longer than one clock.");
  c_tick_seen: cover property (@(posedge sys_clk) disable iff (rst) tick_q);

endmodule

`default_nettype wire

// ---- design/fht_frame_timer.sv ----
// Frame timer: bit-time counter, frame number and low-speed cutoff.
`timescale 1ns/1ps
`default_nettype none

module fht_frame_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic running_state,
  input wire logic [fht_pkg::FR_W-1:0] period_length,
  input wire logic period_load,
  input wire logic interval_toggle_bit,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic ls_req,
  output logic [31:0] cmd_rdata,
  output logic cmd_rvalid,
  output logic [fht_pkg::FR_W-1:0] bits_left_count,
  output logic remaining_toggle_bit,
  output logic [fht_pkg::FN_W-1:0] sof_sequence_count,
  output logic [fht_pkg::LST_W-1:0] low_speed_cutoff,
  output logic sof_event_flag,
  output logic ls_start_grant,
  output logic ls_start_deny
);
  import fht_pkg::*;

  // ==========================================================================
  // Declarations
  fht_tick_if tick_bus ();

  fht_state_type state_q;
  fht_state_type state_d;
  logic running_prev_q;
  logic [FR_W-1:0] period_q;
  logic [FR_W-1:0] period_d;
  logic [FR_W-1:0] count_q;
  logic [FR_W-1:0] count_d;
  logic frt_q;
  logic frt_d;
  logic [FN_W-1:0] fn_q;
  logic [FN_W-1:0] fn_d;
  logic [LST_W-1:0] lst_q;
  logic [LST_W-1:0] lst_d;
  logic sof_q;
  logic grant_q;
  logic deny_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  logic tick;
  logic run_rise;
  logic in_run;
  logic at_zero;
  logic zero_reload;
  logic entry_reload;
  logic any_reload;
  logic dec_now;
  logic ls_ok;
  logic wr_cutoff;
  logic rd_hit;

  // ==========================================================================
  // Bit tick source
  fht_bit_tick u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tk(tick_bus.src)
  );

  assign tick = tick_bus.tick;

  // ==========================================================================
  // Read data decode
  // Every register is built with reserved bits as constant zero.
  function automatic logic [31:0] read_word(
    input logic [7:0] code,
    input logic [FR_W-1:0] cnt,
    input logic toggle,
    input logic [FN_W-1:0] num,
    input logic [LST_W-1:0] cut
  );
    logic [31:0] w;
    w = RD_ZERO;
    if (code == CMD_RD_REMAIN) begin
      w[FR_W-1:0] = cnt;
      w[FRT_POS] = toggle;
    end else if (code == CMD_RD_FRNUM) begin
      w[FN_W-1:0] = num;
    end else if (code == CMD_RD_CUTOFF) begin
      w[LST_W-1:0] = cut;
    end
    return w;
  endfunction

  function automatic logic is_read_code(input logic [7:0] code);
    return (code == CMD_RD_REMAIN) || (code == CMD_RD_FRNUM) ||
           (code == CMD_RD_CUTOFF);
  endfunction

  // ==========================================================================
  // State machine
  assign run_rise = running_state && !running_prev_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      FHT_IDLE: begin
        if (run_rise) begin
          state_d = FHT_START;
        end
      end
      FHT_START: begin
        state_d = running_state ? FHT_RUN : FHT_IDLE;
      end
      FHT_RUN: begin
        if (!running_state) begin
          state_d = FHT_IDLE;
        end
      end
      default: begin
        state_d = FHT_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Frame counters
  assign in_run = state_q == FHT_RUN;
  assign at_zero = count_q == FR_RESET;
  assign entry_reload = state_q == FHT_START;
  assign zero_reload = in_run && tick && at_zero;
  assign any_reload = entry_reload || zero_reload;
  assign dec_now = in_run && tick && !at_zero;

  // A new period only lands in the counter at a reload, so a mid-frame
  // write takes effect from the next start of frame.
  assign period_d = period_load ? period_length : period_q;

  assign count_d = any_reload ? period_q :
                   dec_now ? FR_W'(count_q - 1'b1) :
                   count_q;
  assign frt_d = zero_reload ? interval_toggle_bit : frt_q;
  // Plain 16-bit addition rolls over to zero with nothing else affected.
  assign fn_d = any_reload ? FN_W'(fn_q + 1'b1) : fn_q;

  // ==========================================================================
  // Low-speed cutoff and start gate
  assign wr_cutoff = cmd_valid && (cmd_code == CMD_WR_CUTOFF);
  // Only software's write command touches the cutoff; the counter side never
  // changes it, and bits above the field are dropped.
  assign lst_d = wr_cutoff ? cmd_wdata[LST_W-1:0] : lst_q;
  assign ls_ok = in_run && (count_q >= FR_W'(lst_q));

  // ==========================================================================
  // Command port
  assign rd_hit = cmd_valid && is_read_code(cmd_code);
  assign rvalid_d = rd_hit;
  assign rdata_d = rd_hit ? read_word(cmd_code, count_q, frt_q, fn_q, lst_q) : RD_ZERO;

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= FHT_IDLE;
      running_prev_q <= 1'b0;
      period_q <= FI_RESET;
      count_q <= FR_RESET;
      frt_q <= 1'b0;
      fn_q <= FN_RESET;
      lst_q <= LST_RESET;
    end else begin
      state_q <= state_d;
      running_prev_q <= running_state;
      period_q <= period_d;
      count_q <= count_d;
      frt_q <= frt_d;
      fn_q <= fn_d;
      lst_q <= lst_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sof_q <= 1'b0;
      grant_q <= 1'b0;
      deny_q <= 1'b0;
    end else begin
      sof_q <= any_reload;
      grant_q <= ls_req && ls_ok;
      deny_q <= ls_req && !ls_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign cmd_rdata = rdata_q;
  assign cmd_rvalid = rvalid_q;
  assign bits_left_count = count_q;
  assign remaining_toggle_bit = frt_q;
  assign sof_sequence_count = fn_q;
  assign low_speed_cutoff = lst_q;
  assign sof_event_flag = sof_q;
  assign ls_start_grant = grant_q;
  assign ls_start_deny = deny_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_fr_counts_down: assert property (
    in_run && tick && !at_zero && running_state |=> count_q == $past(count_q) - 14'h0001)
    else $error("Remaining counter did not step down by one.");

  a_fr_reload_zero: assert property (
    in_run && tick && at_zero |=> count_q == $past(period_q))
    else $error("Remaining counter did not reload the period at zero.");

  a_frt_copy_zero: assert property (
    in_run && tick && at_zero |=> frt_q == $past(interval_toggle_bit))
    else $error("Remaining toggle not copied from interval toggle.");

  a_entry_reload_sof: assert property (
    state_q == FHT_IDLE && run_rise
      |=> ##1 count_q == $past(period_q) && sof_q && fn_q == $past(fn_q, 2) + 16'h0001)
    else $error("Entering running did not reload and advance the frame.");

  a_fn_single_step: assert property (
    fn_q != $past(fn_q) |-> fn_q == $past(fn_q) + 16'h0001)
    else $error("Frame number moved by other than one.");

  a_sof_tracks_fn: assert property (
    sof_q == (fn_q != $past(fn_q)))
    else $error("Start-of-frame flag disagrees with frame number advance.");

  a_ls_gate_cutoff: assert property (
    ls_start_grant |-> $past(count_q) >= $past({3'b000, lst_q}) && !ls_start_deny)
    else $error("Low-speed start granted below the cutoff.");

  a_cutoff_held: assert property (
    !wr_cutoff |=> $stable(lst_q))
    else $error("Cutoff changed without a write command.");

  a_rsvd_read_zero: assert property (
    cmd_valid && cmd_code == CMD_RD_FRNUM |=> cmd_rvalid && cmd_rdata[31:16] == 16'h0000)
    else $error("Reserved frame number bits read non-zero.");

  a_no_tick_idle: assert property (
    state_q == FHT_IDLE |=> $stable(count_q))
    else $error("Remaining counter moved while not running.");

  a_sof_on_reload: assert property (
    any_reload |=> sof_q && fn_q == $past(fn_q) + 16'h0001)
    else $error("Reload did not raise start-of-frame and advance the frame.");

  a_fn_only_reload: assert property (
    !any_reload |=> $stable(fn_q))
    else $error("Frame number moved without a reload.");

  a_frt_held: assert property (
    !zero_reload |=> $stable(frt_q))
    else $error("Remaining toggle changed away from a zero reload.");

  a_cutoff_write: assert property (
    wr_cutoff |=> lst_q == $past(cmd_wdata[LST_W-1:0]))
    else $error("Cutoff write did not store the low eleven bits.");

  // Read checks use the state sampled at the taking edge, as software sees it.
  a_remain_read: assert property (
    cmd_valid && cmd_code == CMD_RD_REMAIN |=>
      cmd_rvalid && cmd_rdata == {$past(frt_q), 17'h0_0000, $past(count_q)})
    else $error("Remaining counter read returned a wrong word.");

  a_unknown_quiet: assert property (
    cmd_valid && !is_read_code(cmd_code) |=> !cmd_rvalid && cmd_rdata == RD_ZERO)
    else $error("A non-read command produced read data.");

  // A request answered from a stale count could start a low-speed packet too late.
  a_ls_deny_gate: assert property (
    ls_start_deny |-> !$past(in_run) || $past(count_q) < $past({3'b000, lst_q}))
    else $error("Low-speed start refused although the count allowed it.");

  a_ls_one_answer: assert property (
    ls_req |=> ls_start_grant ^ ls_start_deny)
    else $error("Low-speed request did not get exactly one answer.");

  c_zero_reload: cover property (zero_reload);
  c_entry_start: cover property (entry_reload);
  c_ls_granted: cover property (ls_start_grant);
  c_fn_wrap: cover property (fn_q == 16'hFFFF && any_reload ##1 fn_q == 16'h0000);

endmodule

`default_nettype wire

// ---- test/fht_frame_timer_tb_top.sv ----
// Self-checking testbench for the frame timer through its command port.
`timescale 1ns/1ps
`default_nettype none

module fht_frame_timer_tb_top;
  import fht_pkg::*;

  // ==========================================================================
  // Clock, reset and design
  logic sys_clk;
  logic rst;
  logic running_state;
  logic [FR_W-1:0] period_length;
  logic period_load;
  logic interval_toggle_bit;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [31:0] cmd_wdata;
  logic ls_req;
  logic [31:0] cmd_rdata;
  logic cmd_rvalid;
  logic [FR_W-1:0] bits_left_count;
  logic remaining_toggle_bit;
  logic [FN_W-1:0] sof_sequence_count;
  logic [LST_W-1:0] low_speed_cutoff;
  logic sof_event_flag;
  logic ls_start_grant;
  logic ls_start_deny;
  int err_total = 0;
  int n_tests = 0;
  int sof_seen = 0;

  fht_frame_timer fht_frame_timer_i (
    .sys_clk(sys_clk), .rst(rst), .running_state(running_state),
    .period_length(period_length), .period_load(period_load),
    .interval_toggle_bit(interval_toggle_bit), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .ls_req(ls_req),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .bits_left_count(bits_left_count),
    .remaining_toggle_bit(remaining_toggle_bit), .sof_sequence_count(sof_sequence_count),
    .low_speed_cutoff(low_speed_cutoff), .sof_event_flag(sof_event_flag),
    .ls_start_grant(ls_start_grant), .ls_start_deny(ls_start_deny)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Every one-cycle start-of-frame pulse is counted for the closing balance.
  always @(posedge sys_clk) begin
    if (sof_event_flag === 1'b1) begin
      sof_seen++;
    end
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Writes and unknown codes expect no answer and an idle data bus.
  task automatic cmd(input logic [7:0] code, input logic [31:0] wd, input logic rv,
                     input logic [31:0] exp);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("cmd_rvalid", {31'h0, cmd_rvalid}, {31'h0, rv});
    chk("cmd_rdata", cmd_rdata, exp);
  endtask

  task automatic lsq(input logic g);
    @(posedge sys_clk);
    ls_req <= 1'b1;
    @(posedge sys_clk);
    ls_req <= 1'b0;
    #1;
    chk("ls_start_grant", {31'h0, ls_start_grant}, {31'h0, g});
    chk("ls_start_deny", {31'h0, ls_start_deny}, {31'h0, ~g});
  endtask

  // Running rise is seen one edge late; the counter loads at the edge after that.
  task automatic go(input logic [FR_W-1:0] per, input logic [FN_W-1:0] fn);
    @(posedge sys_clk);
    running_state <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("bits_left_count", {18'h0, bits_left_count}, {18'h0, per});
    chk("sof_sequence_count", {16'h0, sof_sequence_count}, {16'h0, fn});
    chk("sof_event_flag", {31'h0, sof_event_flag}, 32'h0000_0001);
  endtask

  // Polls every cycle, so a match is seen in the first cycle of the new count.
  task automatic wait_cnt(input logic [FR_W-1:0] v);
    int i;
    for (i = 0; i < 600 && bits_left_count !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("bits_left_count", {18'h0, bits_left_count}, {18'h0, v});
  endtask

  task automatic wait_chg(input logic [FR_W-1:0] v);
    int i;
    for (i = 0; i < 40 && bits_left_count === v; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    rst = 1'b1;
    running_state = 1'b0;
    period_length = 14'h0000;
    period_load = 1'b0;
    interval_toggle_bit = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0000_0000;
    ls_req = 1'b0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    cmd(8'h11, 32'h0000_0000, 1'b1, 32'h0000_0628);
    chk("low_speed_cutoff", {21'h0, low_speed_cutoff}, 32'h0000_0628);
    cmd(8'h0F, 32'h0000_0000, 1'b1, 32'h0000_0000);
    cmd(8'h0E, 32'h0000_0000, 1'b1, 32'h0000_0000);
    cmd(8'h91, 32'hFFFF_F80A, 1'b0, 32'h0000_0000);
    chk("low_speed_cutoff", {21'h0, low_speed_cutoff}, 32'h0000_000A);
    cmd(8'h11, 32'h0000_0000, 1'b1, 32'h0000_000A);
    cmd(8'h8F, 32'h0000_1234, 1'b0, 32'h0000_0000);
    cmd(8'h8E, 32'h0000_1234, 1'b0, 32'h0000_0000);
    cmd(8'h0F, 32'h0000_0000, 1'b1, 32'h0000_0000);
    lsq(1'b0);
    go(14'h2EDF, 16'h0001);
    lsq(1'b1);
    @(posedge sys_clk);
    running_state <= 1'b0;
    period_length <= 14'h0014;
    period_load <= 1'b1;
    interval_toggle_bit <= 1'b1;
    @(posedge sys_clk);
    period_load <= 1'b0;
    go(14'h0014, 16'h0002);
    wait_chg(14'h0014);
    chk("bits_left_count", {18'h0, bits_left_count}, 32'h0000_0013);
    wait_cnt(14'h000A);
    lsq(1'b1);
    wait_cnt(14'h0009);
    lsq(1'b0);
    wait_cnt(14'h0000);
    wait_chg(14'h0000);
    chk("bits_left_count", {18'h0, bits_left_count}, 32'h0000_0014);
    chk("sof_sequence_count", {16'h0, sof_sequence_count}, 32'h0000_0003);
    chk("remaining_toggle_bit", {31'h0, remaining_toggle_bit}, 32'h0000_0001);
    wait_cnt(14'h0005);
    @(posedge sys_clk);
    running_state <= 1'b0;
    repeat (40) @(posedge sys_clk);
    #1;
    chk("bits_left_count", {18'h0, bits_left_count}, 32'h0000_0005);
    cmd(8'h0E, 32'h0000_0000, 1'b1, 32'h8000_0005);
    cmd(8'h0F, 32'h0000_0000, 1'b1, 32'h0000_0003);
    chk("low_speed_cutoff", {21'h0, low_speed_cutoff}, 32'h0000_000A);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("sof pulses", 32'(sof_seen), 32'h0000_0003);
    stop_test();
  end

  // The whole sequence needs a few hundred cycles; this limit is generous.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    $display("mismatch watchdog expected done seen timeout");
    stop_test();
  end
endmodule

`default_nettype wire
